/* File: design/css_supervisor.sv */
// digital supervisor of a single-cell linear charger: phases, faults,
// status leds, pulse-count status line and an ahb-lite register slave
// assumes analog comparators drive the flag pins asynchronously, and
// that the supply-low lockout also drives rst_n low at power-up
//
// Notes on behaviour
// - level select high picks high current
// - level select low picks low current
// - supply below trip keeps reduction active
// - undervoltage lockout suspends charging, shuts down
// - after lockout, re-evaluate cell, pick phase
// - enable low forces sleep, charging stops
// - enable high restarts charge control freshly
// - overvoltage holds shutdown until voltage falls
// - overvoltage shows fault leds and line code
// - die over-temperature shuts charging down
// - cell over-temperature: pass off, report, leds
// - temperature fault clearing resumes charging automatically
// - cell temperature checked before and during charge
// - thermistor outside window halts charge, signals fault
// - disabled or low supply: both leds off
// - enabled without cell: both leds flash
// - charging, complete and fault led patterns
// - led outputs are open-drain pull-down switches
// - primary led alone tells charging state
// - host asks, device answers encoded state
// - precondition, then constant current, then voltage
// - terminate at low current, sleep until recharge
// - request low 200ns, pulses after release
// - counts one, two, three for faults
`timescale 1ns/1ps

module css_supervisor
	import css_pkg::*;
#(
	parameter int FLASH_CYC = FLASH_HALF_CYC
) (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               supplyLow,
	input  wire logic               supplyBelowTrip,
	input  wire logic               cellOverVolt,
	input  wire logic               dieOverTemp,
	input  wire logic               thermBelowHot,
	input  wire logic               thermAboveCold,
	input  wire logic               cellBelowPrecond,
	input  wire logic               cellAtRegulation,
	input  wire logic               currentBelowTerm,
	input  wire logic               cellBelowRecharge,
	input  wire logic               cellPresent,
	input  wire logic               chargeLevelSelect,
	input  wire logic               enable,
	input  wire logic               statusLineIn,
	output logic                    statusLineOut,
	output logic                    statusLineOe,
	output logic                    ledPrimaryOut,
	output logic                    ledPrimaryOe,
	output logic                    ledSecondaryOut,
	output logic                    ledSecondaryOe,
	output logic                    passOn,
	output logic                    highLevelOn,
	output logic                    reductionOn,
	output logic                    trickleOn,
	output logic                    constVoltOn,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic [31:0]             hrdata,
	output logic                    hreadyout,
	output logic                    hresp
);

	// three-stage synchronisers and agreement filter
	logic [NIN-1:0]    rawIn;      // pins gathered into one vector
	logic [NIN-1:0]    s1_q;       // first stage, read only by s2
	logic [NIN-1:0]    s2_q;       // second stage
	logic [NIN-1:0]    s3_q;       // third stage
	logic [NIN-1:0]    filt_q;     // accepted input levels
	logic [NIN-1:0]    filt_d;

	assign rawIn = {statusLineIn, enable, chargeLevelSelect, cellPresent,
		cellBelowRecharge, currentBelowTerm, cellAtRegulation,
		cellBelowPrecond, thermAboveCold, thermBelowHot, dieOverTemp,
		cellOverVolt, supplyBelowTrip, supplyLow};

	generate
		for (genvar i = 0; i < NIN; i++) begin : g_filt
			assign filt_d[i] = (s2_q[i] == s3_q[i]) ? s2_q[i] : filt_q[i];
		end
	endgenerate

	// synchroniser chain; a level counts once stages two and three agree
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_q   <= SYNC_RST;
			s2_q   <= SYNC_RST;
			s3_q   <= SYNC_RST;
			filt_q <= SYNC_RST;
		end else begin
			s1_q   <= rawIn;
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			filt_q <= filt_d;
		end
	end

	// software control bit, also gates the enable pin
	logic              softEn_q;

	// decoded qualified inputs
	wire lockout   = filt_q[IN_UVLO];
	wire belowTrip = filt_q[IN_REDUCE];
	wire overV     = filt_q[IN_OVERV];
	wire dieHot    = filt_q[IN_DIE_HOT];
	wire levelHigh = filt_q[IN_LEVEL];
	wire lineIn    = filt_q[IN_DATA];
	// enable pin and software bit both needed
	wire chgEn     = filt_q[IN_EN] & softEn_q;
	// outside thermistor window on either side
	wire cellTemp  = filt_q[IN_CELL_HOT] | filt_q[IN_CELL_COLD];
	wire anyFault  = dieHot | cellTemp | overV;

	// charge control state machine
	css_chg_e          chg_q;
	css_chg_e          chg_d;

	// next phase; lockout first, then enable, then faults
	always_comb begin
		chg_d = chg_q;
		if (lockout) begin
			chg_d = CSS_OFF;
		end else if (!chgEn) begin
			chg_d = CSS_SLEEP;
		end else if (anyFault) begin
			chg_d = CSS_FAULT;
		// a removed cell ends any phase
		end else if (!filt_q[IN_PRESENT]) begin
			chg_d = CSS_NOCELL;
		end else begin
			case (chg_q)
				CSS_OFF: chg_d = CSS_CHECK;
				CSS_SLEEP: chg_d = CSS_CHECK;
				CSS_FAULT: chg_d = CSS_CHECK;
				CSS_NOCELL: begin
					if (filt_q[IN_PRESENT]) begin
						chg_d = CSS_CHECK;
					end
				end
				CSS_CHECK: begin
					if (!filt_q[IN_PRESENT]) begin
						chg_d = CSS_NOCELL;
					end else if (filt_q[IN_PRECOND]) begin
						chg_d = CSS_PRE;
					end else if (filt_q[IN_REG]) begin
						chg_d = CSS_CV;
					end else begin
						chg_d = CSS_CC;
					end
				end
				CSS_PRE: begin
					if (!filt_q[IN_PRECOND]) begin
						chg_d = CSS_CC;
					end
				end
				CSS_CC: begin
					if (filt_q[IN_REG]) begin
						chg_d = CSS_CV;
					end
				end
				CSS_CV: begin
					if (filt_q[IN_ITERM]) begin
						chg_d = CSS_DONE;
					end
				end
				CSS_DONE: begin
					if (filt_q[IN_RECHG]) begin
						chg_d = CSS_CHECK;
					end
				end
				default: chg_d = CSS_CHECK;
			endcase
		end
	end

	// phase register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			chg_q <= CSS_OFF;
		end else begin
			chg_q <= chg_d;
		end
	end

	// phase decodes
	wire inPre     = (chg_q == CSS_PRE);
	wire inCc      = (chg_q == CSS_CC);
	wire inCv      = (chg_q == CSS_CV);
	wire charging  = inPre | inCc | inCv;
	wire inDone    = (chg_q == CSS_DONE);
	wire inFault   = (chg_q == CSS_FAULT);
	wire inNoCell  = (chg_q == CSS_NOCELL);

	// encoded state for the status line and register
	logic [CODE_W-1:0] code_q;
	logic [CODE_W-1:0] modeBase;
	logic [CODE_W-1:0] code_d;

	assign modeBase = levelHigh ? CODE_HI_BASE : CODE_LO_BASE;

	// fault causes map to one, two, three
	// fault codes checked before phase codes
	assign code_d = dieHot ? CODE_DIE :
		cellTemp ? CODE_CELLTEMP :
		overV ? CODE_OVER :
		inPre ? modeBase + OFS_PRE :
		(inCc && belowTrip) ? modeBase + OFS_RED :
		inCc ? modeBase + OFS_CC :
		inCv ? modeBase + OFS_CV :
		inDone ? modeBase + OFS_EOC : CODE_ERR;

	// no-cell flashing timebase; long count, so shortened in simulation
	logic [FLASH_W-1:0] flashCnt_q;
	logic               flashPh_q;
	wire flashWrap = (flashCnt_q == FLASH_W'(FLASH_CYC - 1));

	// free-running divider toggles the flash phase
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flashCnt_q <= '0;
			flashPh_q  <= 1'b0;
		end else if (flashWrap) begin
			flashCnt_q <= '0;
			flashPh_q  <= ~flashPh_q;
		end else begin
			flashCnt_q <= flashCnt_q + 1'b1;
		end
	end

	// led switch states; off/sleep/check leave both dark
	// off unless a lit case applies
	// primary alone means charging; a fault lights both
	// charging lamp drops with the pass device, so it never lies
	wire priOn = (charging & ~anyFault) | inFault | (inNoCell & flashPh_q);
	wire secOn = inDone | inFault | (inNoCell & flashPh_q);

	// status line reporter
	css_rep_e          rep_q;
	logic [CNT_W-1:0]  repCnt_q;   // low time, delay or half period
	logic [CODE_W-1:0] repLeft_q;  // pulses still to send
	logic              lineOe_q;
	wire reqLongEnough = (repCnt_q >= CNT_W'(REQ_MIN_CYC));
	wire delayDone     = (repCnt_q == CNT_W'(REPORT_DELAY_CYC - 1));
	wire halfDone      = (repCnt_q == CNT_W'(DATA_HALF_CYC - 1));
	wire cntSat        = (repCnt_q == {CNT_W{1'b1}});
	wire lastPulse     = (repLeft_q == CODE_W'(1));

	// request detection and pulse train; own pulses are not requests
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rep_q     <= CSS_R_IDLE;
			repCnt_q  <= '0;
			repLeft_q <= '0;
			lineOe_q  <= 1'b0;
		end else begin
			case (rep_q)
				// host interrogation starts with a low
				CSS_R_IDLE: begin
					repCnt_q <= '0;
					lineOe_q <= 1'b0;
					if (!lineIn) begin
						rep_q <= CSS_R_REQ;
					end
				end
				// measure the low, act on release
				CSS_R_REQ: begin
					if (lineIn) begin
						repCnt_q <= '0;
						// too short a low is dropped
						rep_q    <= reqLongEnough ? CSS_R_WAIT : CSS_R_IDLE;
					end else if (!cntSat) begin
						repCnt_q <= repCnt_q + 1'b1;
					end
				end
				// state sampled at the end of the delay
				CSS_R_WAIT: begin
					if (delayDone) begin
						repCnt_q  <= '0;
						repLeft_q <= code_q;
						lineOe_q  <= 1'b1;
						rep_q     <= CSS_R_LOW;
					end else begin
						repCnt_q <= repCnt_q + 1'b1;
					end
				end
				// one low half per counted pulse
				CSS_R_LOW: begin
					if (halfDone) begin
						repCnt_q <= '0;
						lineOe_q <= 1'b0;
						rep_q    <= CSS_R_HIGH;
					end else begin
						repCnt_q <= repCnt_q + 1'b1;
					end
				end
				// high half, then next pulse or done
				CSS_R_HIGH: begin
					if (halfDone) begin
						repCnt_q  <= '0;
						repLeft_q <= repLeft_q - 1'b1;
						lineOe_q  <= ~lastPulse;
						rep_q     <= lastPulse ? CSS_R_IDLE : CSS_R_LOW;
					end else begin
						repCnt_q <= repCnt_q + 1'b1;
					end
				end
				default: rep_q <= CSS_R_IDLE;
			endcase
		end
	end

	// registered outputs of the charge path and leds
	logic ledPriOe_q;
	logic ledSecOe_q;
	logic pass_q;
	logic high_q;
	logic reduce_q;
	logic trickle_q;
	logic cv_q;
	logic driveLow_q;              // level of every open-drain pin

	// output flops; pass device follows the charging phases only
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			code_q     <= CODE_ERR;
			ledPriOe_q <= 1'b0;
			ledSecOe_q <= 1'b0;
			pass_q     <= 1'b0;
			high_q     <= 1'b0;
			reduce_q   <= 1'b0;
			trickle_q  <= 1'b0;
			cv_q       <= 1'b0;
			driveLow_q <= 1'b0;
		end else begin
			code_q     <= code_d;
			ledPriOe_q <= priOn;
			ledSecOe_q <= secOn;
			pass_q     <= charging & ~anyFault;
			high_q     <= levelHigh;
			// reduction while supply sags in fast charge
			reduce_q   <= belowTrip & (inCc | inCv);
			trickle_q  <= inPre;
			cv_q       <= inCv;
			driveLow_q <= 1'b0;
		end
	end

	// status line carries the encoded state
	assign statusLineOut   = driveLow_q;
	assign statusLineOe    = lineOe_q;
	assign ledPrimaryOut   = driveLow_q;
	assign ledPrimaryOe    = ledPriOe_q;
	assign ledSecondaryOut = driveLow_q;
	assign ledSecondaryOe  = ledSecOe_q;
	assign passOn          = pass_q;
	assign highLevelOn     = high_q;
	assign reductionOn     = reduce_q;
	assign trickleOn       = trickle_q;
	assign constVoltOn     = cv_q;

	// ahb-lite slave: zero wait states, always okay
	logic              wrPend_q;   // write data phase pending
	logic [ADDR_W-1:0] wrAddr_q;
	logic [31:0]       hrdata_q;
	logic              hready_q;
	logic [31:0]       rdData;
	logic [31:0]       statusWord;
	wire addrAct = hsel & htrans[HTRANS_ACT_BIT] & hready;
	wire rdAct   = addrAct & ~hwrite;
	wire ctrlWr  = wrPend_q & (wrAddr_q == ADDR_CTRL);

	// status word: code, phase, pass device, report busy
	always_comb begin
		statusWord = '0;
		statusWord[ST_CODE_LSB +: CODE_W] = code_q;
		statusWord[ST_STATE_LSB +: 4] = chg_q;
		statusWord[ST_PASS_BIT] = pass_q;
		statusWord[ST_RPT_BIT] = (rep_q != CSS_R_IDLE);
	end

	// read mux; unmapped addresses read zero
	assign rdData = (haddr[ADDR_W-1:0] == ADDR_CTRL) ?
			{31'h0, softEn_q} :
		(haddr[ADDR_W-1:0] == ADDR_STATUS) ? statusWord :
		(haddr[ADDR_W-1:0] == ADDR_INPUT) ? {18'h0, filt_q} : 32'h0;

	// address phase capture and data phase write
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wrPend_q <= 1'b0;
			wrAddr_q <= '0;
			hrdata_q <= '0;
			hready_q <= 1'b1;
			softEn_q <= CTRL_EN_RST;
		end else begin
			wrPend_q <= addrAct & hwrite;
			hready_q <= 1'b1;
			if (addrAct) begin
				wrAddr_q <= haddr[ADDR_W-1:0];
			end
			hrdata_q <= rdAct ? rdData : 32'h0;
			if (ctrlWr) begin
				softEn_q <= hwdata[CTRL_EN_BIT];
			end
		end
	end

	assign hrdata    = hrdata_q;
	assign hreadyout = hready_q;
	assign hresp     = HRESP_OKAY;

endmodule

/* File: design/css_pkg.sv */
// constants, field layout and state types of the charge supervisor
// assumes a single 20 MHz system clock shared by every user of the package
package css_pkg;

	// clock rate in MHz
	localparam int CLK_MHZ          = 20;
	// least low time of a status request
	localparam int REQ_MIN_NS       = 200;
	localparam int REQ_MIN_CYC      = (REQ_MIN_NS * CLK_MHZ + 999) / 1000;
	// period of one returned status pulse
	localparam int DATA_PERIOD_US   = 50;
	localparam int DATA_PERIOD_CYC  = DATA_PERIOD_US * CLK_MHZ;
	localparam int DATA_HALF_CYC    = DATA_PERIOD_CYC / 2;
	// wait from request release to the first pulse
	localparam int REPORT_DELAY_US  = 50;
	localparam int REPORT_DELAY_CYC = REPORT_DELAY_US * CLK_MHZ;
	// half period of the no-cell led flashing
	localparam int FLASH_HALF_MS    = 250;
	localparam int FLASH_HALF_CYC   = FLASH_HALF_MS * CLK_MHZ * 1000;

	// counter widths
	localparam int CNT_W            = 16;
	localparam int FLASH_W          = 23;
	localparam int CODE_W           = 5;

	// positions of the pin inputs in the synchroniser vector
	localparam int IN_UVLO          = 0;
	localparam int IN_REDUCE        = 1;
	localparam int IN_OVERV         = 2;
	localparam int IN_DIE_HOT       = 3;
	localparam int IN_CELL_HOT      = 4;
	localparam int IN_CELL_COLD     = 5;
	localparam int IN_PRECOND       = 6;
	localparam int IN_REG           = 7;
	localparam int IN_ITERM         = 8;
	localparam int IN_RECHG         = 9;
	localparam int IN_PRESENT       = 10;
	localparam int IN_LEVEL         = 11;
	localparam int IN_EN            = 12;
	localparam int IN_DATA          = 13;
	localparam int NIN              = 14;
	// data line idles high, every flag idles low
	localparam logic [NIN-1:0] SYNC_RST = 14'h2000;

	// returned pulse counts
	localparam logic [CODE_W-1:0] CODE_DIE      = 5'h01;
	localparam logic [CODE_W-1:0] CODE_CELLTEMP = 5'h02;
	localparam logic [CODE_W-1:0] CODE_OVER     = 5'h03;
	localparam logic [CODE_W-1:0] CODE_HI_BASE  = 5'h0d;
	localparam logic [CODE_W-1:0] CODE_LO_BASE  = 5'h12;
	localparam logic [CODE_W-1:0] CODE_ERR      = 5'h17;
	localparam logic [CODE_W-1:0] OFS_PRE       = 5'h00;
	localparam logic [CODE_W-1:0] OFS_RED       = 5'h01;
	localparam logic [CODE_W-1:0] OFS_CC        = 5'h02;
	localparam logic [CODE_W-1:0] OFS_CV        = 5'h03;
	localparam logic [CODE_W-1:0] OFS_EOC       = 5'h04;

	// register map, byte addresses
	localparam int ADDR_W                       = 8;
	localparam logic [ADDR_W-1:0] ADDR_CTRL     = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_STATUS   = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_INPUT    = 8'h08;
	localparam int CTRL_EN_BIT                  = 0;
	localparam logic CTRL_EN_RST                = 1'b1;
	localparam int ST_CODE_LSB                  = 0;
	localparam int ST_STATE_LSB                 = 8;
	localparam int ST_PASS_BIT                  = 16;
	localparam int ST_RPT_BIT                   = 17;
	localparam int HTRANS_ACT_BIT               = 1;
	localparam logic HRESP_OKAY                 = 1'b0;

	// charge control states
	typedef enum logic [3:0] {
		CSS_OFF, CSS_SLEEP, CSS_CHECK, CSS_NOCELL, CSS_PRE,
		CSS_CC, CSS_CV, CSS_DONE, CSS_FAULT
	} css_chg_e;

	// status line reporter states
	typedef enum logic [2:0] {
		CSS_R_IDLE, CSS_R_REQ, CSS_R_WAIT, CSS_R_LOW, CSS_R_HIGH
	} css_rep_e;

endpackage

/* File: sim/css_supervisor_monitor.sv */
// pin-level checks of the charge supervisor, bound onto its top module
// assumes one clock, synchronous active-low reset, flags held steady
`timescale 1ns/1ps

module css_supervisor_monitor
	import css_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic supplyLow,
	input wire logic cellOverVolt,
	input wire logic dieOverTemp,
	input wire logic thermBelowHot,
	input wire logic cellPresent,
	input wire logic chargeLevelSelect,
	input wire logic enable,
	input wire logic statusLineOut,
	input wire logic statusLineOe,
	input wire logic ledPrimaryOut,
	input wire logic ledPrimaryOe,
	input wire logic ledSecondaryOut,
	input wire logic ledSecondaryOe,
	input wire logic passOn,
	input wire logic highLevelOn
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// cycles the device has held the status line low so far
	logic [CNT_W-1:0] oeRun_q;
	always_ff @(posedge clk) begin
		if (!rst_n || !statusLineOe)
			oeRun_q <= '0;
		else
			oeRun_q <= oeRun_q + 1'b1;
	end

	// overvoltage while powered and enabled, held past the filter depth
	sequence s_ovHeld;
		(cellOverVolt && enable && !supplyLow && cellPresent)[*8] ##1
		(cellOverVolt && enable && !supplyLow && cellPresent)[*4];
	endsequence

	a_pins_sink_only: assert property (
		!ledPrimaryOut && !ledSecondaryOut && !statusLineOut)
		else $error("open-drain output driven high");
	a_ov_pass_off: assert property (
		cellOverVolt[*8] |=> !passOn)
		else $error("pass device on during overvoltage");
	a_die_pass_off: assert property (
		dieOverTemp[*8] |=> !passOn)
		else $error("pass device on with die too hot");
	a_hot_pass_off: assert property (
		thermBelowHot[*8] |=> !passOn)
		else $error("pass device on with cell too hot");
	a_sleep_all_off: assert property (
		(!enable)[*8] |=> !passOn && !ledPrimaryOe && !ledSecondaryOe)
		else $error("activity while disabled");
	a_uvlo_all_off: assert property (
		supplyLow[*8] |=> !passOn && !ledPrimaryOe && !ledSecondaryOe)
		else $error("activity with supply low");
	a_ov_fault_leds: assert property (
		s_ovHeld |=> ledPrimaryOe && ledSecondaryOe && !passOn)
		else $error("overvoltage not shown as fault");
	a_level_high: assert property (
		chargeLevelSelect[*8] ##1 passOn |-> highLevelOn)
		else $error("high level not applied");
	a_level_low: assert property (
		(!chargeLevelSelect)[*8] |=> !highLevelOn)
		else $error("low level not applied");
	a_primary_alone: assert property (
		ledPrimaryOe && !ledSecondaryOe |-> passOn)
		else $error("primary led alone without charging");
	a_pulse_width: assert property (
		$fell(statusLineOe) |-> oeRun_q == DATA_HALF_CYC)
		else $error("status pulse of wrong length");
endmodule

bind css_supervisor css_supervisor_monitor i_css_supervisor_monitor (
	.clk(clk), .rst_n(rst_n), .supplyLow(supplyLow),
	.cellOverVolt(cellOverVolt), .dieOverTemp(dieOverTemp),
	.thermBelowHot(thermBelowHot), .cellPresent(cellPresent),
	.chargeLevelSelect(chargeLevelSelect), .enable(enable),
	.statusLineOut(statusLineOut), .statusLineOe(statusLineOe),
	.ledPrimaryOut(ledPrimaryOut), .ledPrimaryOe(ledPrimaryOe),
	.ledSecondaryOut(ledSecondaryOut), .ledSecondaryOe(ledSecondaryOe),
	.passOn(passOn), .highLevelOn(highLevelOn));

/* File: sim/css_host_model.sv */
// host side of the status line: pull-up, request strobe, pulse counter
// assumes the bench calls request right after a rising clock edge
`timescale 1ns/1ps

module css_host_model
	import css_pkg::*;
(
	input wire logic          clk,
	input wire logic          rst_n,
	input wire logic          statusLineOut,
	input wire logic          statusLineOe,
	output logic              lineLevel,
	output logic              trainDone,
	output logic [CODE_W-1:0] pulseCnt
);
	logic             hostLow = 1'b0;  // host pulling the line low
	logic             oePrev = 1'b0;   // device drive one cycle ago
	logic [CNT_W-1:0] idleCnt = '0;    // cycles since the last pulse

	// wired line, released means pulled high
	assign lineLevel = !(hostLow || (statusLineOe && !statusLineOut));

	task automatic request(input int len);
		hostLow <= 1'b1;
		repeat (len) @(posedge clk);
		hostLow <= 1'b0;
	endtask

	// counts device pulses, ends a train 1500 cycles after the last pulse starts
	always @(posedge clk) begin
		oePrev <= statusLineOe;
		trainDone <= 1'b0;
		if (!rst_n || hostLow) begin
			pulseCnt <= '0;
			idleCnt <= '0;
		end else if (statusLineOe && !oePrev) begin
			pulseCnt <= pulseCnt + 1'b1;
			idleCnt <= '0;
		end else if (pulseCnt != '0 && idleCnt < 16'd1500) begin
			idleCnt <= idleCnt + 1'b1;
			trainDone <= (idleCnt == 16'd1499);
		end
	end
endmodule

/* File: sim/css_supervisor_bench.sv */
// self-checking bench of the charge supervisor over ahb-lite and pins
// assumes the monitor binds itself and the host model owns the line
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
	$display("Error at %0t got %h exp %h", $time, (g), (e)); end end

module css_supervisor_bench
	import css_pkg::*;
;
	localparam int FL = 8;  // short flash half period keeps the run brief
	// flag pins in synchroniser order
	localparam logic [12:0] UV = 13'h0001, TR = 13'h0002, OV = 13'h0004;
	localparam logic [12:0] DH = 13'h0008, TH = 13'h0010, TC = 13'h0020;
	localparam logic [12:0] PC = 13'h0040, RG = 13'h0080, IT = 13'h0100;
	localparam logic [12:0] RC = 13'h0200, B = 13'h1400, H = 13'h1c00;
	localparam logic [4:0]  HI = CODE_HI_BASE, LO = CODE_LO_BASE;

	logic              clk, rst_n, hsel, hwrite, rdPh, hreadyout, hresp;
	logic [12:0]       pins;       // flag pins, driven on the clock edge
	logic [1:0]        htrans;
	logic [31:0]       haddr, hwdata, hrdata;
	logic              lineIn, lineOut, lineOe, lpOut, lpOe, lsOut, lsOe;
	logic              passOn, hiOn, redOn, trkOn, cvOn, trainDone;
	logic [CODE_W-1:0] pulseCnt;
	logic [37:0]       expQ[$], mskQ[$];  // notes for the watcher
	int                error_cnt, checks_done, cycles;

	css_supervisor #(.FLASH_CYC(FL)) i_css_supervisor (
		.clk(clk), .rst_n(rst_n), .supplyLow(pins[0]),
		.supplyBelowTrip(pins[1]), .cellOverVolt(pins[2]),
		.dieOverTemp(pins[3]), .thermBelowHot(pins[4]),
		.thermAboveCold(pins[5]), .cellBelowPrecond(pins[6]),
		.cellAtRegulation(pins[7]), .currentBelowTerm(pins[8]),
		.cellBelowRecharge(pins[9]), .cellPresent(pins[10]),
		.chargeLevelSelect(pins[11]), .enable(pins[12]),
		.statusLineIn(lineIn), .statusLineOut(lineOut),
		.statusLineOe(lineOe), .ledPrimaryOut(lpOut), .ledPrimaryOe(lpOe),
		.ledSecondaryOut(lsOut), .ledSecondaryOe(lsOe), .passOn(passOn),
		.highLevelOn(hiOn), .reductionOn(redOn), .trickleOn(trkOn),
		.constVoltOn(cvOn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp));

	css_host_model i_css_host_model (.clk(clk), .rst_n(rst_n),
		.statusLineOut(lineOut), .statusLineOe(lineOe),
		.lineLevel(lineIn), .trainDone(trainDone), .pulseCnt(pulseCnt));

	// free-running 50 ns clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// takes the oldest note whenever read data or a pulse train shows
	always @(posedge clk) begin
		logic [37:0] e;
		logic [37:0] m;
		if (rdPh && hreadyout === 1'b1) begin
			e = expQ.pop_front();
			m = mskQ.pop_front();
			`CHK({lpOe, lsOe, hiOn, redOn, trkOn, cvOn, hrdata} & m, e)
			`CHK(hresp, HRESP_OKAY)
		end
		if (trainDone === 1'b1) begin
			e = expQ.pop_front();
			`CHK({33'h0, pulseCnt}, e)
		end
	end

	// hang guard, well above the expected run length
	always @(posedge clk) begin
		cycles++;
		if (cycles > 40000) begin
			error_cnt++;
			results();
		end
	end

	task automatic results();
		if (error_cnt == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// single word transfer; held until hready, read data seen by watcher
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		rdPh <= !w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rdPh <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [37:0] e, m);
		expQ.push_back(e & m);
		mskQ.push_back(m);
		xfer(1'b0, a, 32'h0);
	endtask

	// new pins, settle, then note outputs and status; flashing leds
	// and the level flag outside charging are left out of the compare
	task automatic step(input logic [12:0] p, input logic [5:0] o,
		input logic [3:0] s, input logic [4:0] c, input logic ps);
		logic [5:0] m;
		m = {(s == CSS_NOCELL) ? 2'b00 : 2'b11, ps, 3'b111};
		pins <= p;
		repeat (30) @(posedge clk);
		rd(ADDR_STATUS, {o, 15'h0, ps, 4'h0, s, 3'h0, c}, {m, 32'h10f1f});
	endtask

	initial begin
		logic f;
		{pins, hsel, hwrite, rdPh, htrans, haddr, hwdata} = '0;
		rst_n = 1'b0;
		error_cnt = 0;
		checks_done = 0;
		cycles = 0;
		void'($urandom(68));
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		rd(ADDR_CTRL, 38'h1, 38'hffffffff);
		xfer(1'b1, 8'h0c, $urandom);
		rd(8'h0c, 38'h0, 38'hffffffff);
		step(H|PC, 6'h2a, CSS_PRE, HI+OFS_PRE, 1'b1);
		step(H, 6'h28, CSS_CC, HI+OFS_CC, 1'b1);
		step(H|TR, 6'h2c, CSS_CC, HI+OFS_RED, 1'b1);
		step(B, 6'h20, CSS_CC, LO+OFS_CC, 1'b1);
		step(B|RG, 6'h21, CSS_CV, LO+OFS_CV, 1'b1);
		step(B|RG|IT, 6'h10, CSS_DONE, LO+OFS_EOC, 1'b0);
		step(B|RC, 6'h20, CSS_CC, LO+OFS_CC, 1'b1);
		step(H|OV, 6'h30, CSS_FAULT, CODE_OVER, 1'b0);
		step(H|OV|TH, 6'h30, CSS_FAULT, CODE_CELLTEMP, 1'b0);
		step(H|OV|TH|DH, 6'h30, CSS_FAULT, CODE_DIE, 1'b0);
		step(H, 6'h28, CSS_CC, HI+OFS_CC, 1'b1);
		step(13'h0c00, 6'h00, CSS_SLEEP, CODE_ERR, 1'b0);
		step(H|PC, 6'h2a, CSS_PRE, HI+OFS_PRE, 1'b1);
		step(H|PC|UV, 6'h00, CSS_OFF, CODE_ERR, 1'b0);
		step(H|PC, 6'h2a, CSS_PRE, HI+OFS_PRE, 1'b1);
		step(H|PC|TC, 6'h30, CSS_FAULT, CODE_CELLTEMP, 1'b0);
		// soft disable through the control register
		xfer(1'b1, ADDR_CTRL, $urandom & 32'hfffffffe);
		rd(ADDR_CTRL, 38'h0, 38'h1);
		step(H, 6'h00, CSS_SLEEP, CODE_ERR, 1'b0);
		xfer(1'b1, ADDR_CTRL, 32'h1);
		rd(ADDR_INPUT, {24'h0, 1'b1, H}, 38'h3fff);
		step(13'h1800, 6'h00, CSS_NOCELL, CODE_ERR, 1'b0);
		f = lpOe;
		repeat (FL) @(posedge clk);
		`CHK({lpOe, lsOe}, {~f, ~f})
		// one pulse train per fault code
		for (int i = 0; i < 3; i++) begin
			pins <= H | ((i == 0) ? DH : (i == 1) ? TH : OV);
			repeat (30) @(posedge clk);
			expQ.push_back(38'(i + 1));
			i_css_host_model.request(5);
			do @(posedge clk); while (trainDone !== 1'b1);
		end
		// a strobe shorter than the minimum is ignored
		i_css_host_model.request(2);
		repeat (2500) @(posedge clk);
		`CHK(pulseCnt, 5'h0)
		xfer(1'b1, ADDR_CTRL, 32'h0);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(ADDR_CTRL, 38'h1, 38'hffffffff);
		results();
	end
endmodule
